// [src/rmis_defs.vh]
/*
 * Constants for the relative move and input status block: status word layout,
 * error codes, command codes and trajectory modes.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef RMIS_DEFS_VH
`define RMIS_DEFS_VH

`define RMIS_NUM_AXES 6
`define RMIS_HOME_LSB 0
`define RMIS_INDEX_LSB 8
`define RMIS_DIN_LSB 16
`define RMIS_STATUS_RESET 32'h00000000

`define RMIS_CMD_NONE 2'h0
`define RMIS_CMD_STATUS 2'h1
`define RMIS_CMD_MOVE 2'h2

`define RMIS_ERR_NONE 8'h00
`define RMIS_ERR_AXIS_MISSING 8'h25
`define RMIS_ERR_AXIS_RANGE 8'h09
`define RMIS_ERR_PARAM_MISSING 8'h26
`define RMIS_ERR_POS_HW_LIMIT 8'h04
`define RMIS_ERR_NEG_HW_LIMIT 8'h05
`define RMIS_ERR_POS_SW_LIMIT 8'h06
`define RMIS_ERR_NEG_SW_LIMIT 8'h07
`define RMIS_ERR_GROUP 8'h1f
`define RMIS_ERR_TRAJ_MODE 8'h20

`define RMIS_TRAJ_TRAP 2'h0
`define RMIS_TRAJ_SCURVE 2'h1

`define RMIS_HEX_DIGITS 4'h8

`endif

// [src/rmis_core.v]
/*
 * Relative move checker and input level status reporter.
 * Assumes a command decoder that presents parsed fields with a one-cycle strobe,
 * per-axis trajectory generators that take a target with a start pulse, and
 * raw asynchronous input pins for home, index and digital inputs.
 */
// How it works
// - Status bits 0..5 follow home input level of axes 1..6.
// - Bits 8..13 follow index inputs; bits 6,7,14,15,31 read zero.
// - Bits 16..18 follow digital inputs A, B and C.
// - Status request sends the status word as hexadecimal text characters.
// - Missing axis gives code 37; axis outside 1..fitted gives code 9.
// - Missing distance gives code 38 and starts no motion.
// - Move into positive or negative hardware limit gives xx04 or xx05.
// - Move past positive or negative software limit gives xx06 or xx07.
// - Displacement magnitude must stay within the per-axis resolution bound; the check misses the most negative distance.
// - Accepted move targets current position plus displacement, using configured profile.
// - Axis in a group gives xx31 and starts nothing.
// - Trajectory mode not trapezoidal or s-curve gives xx32.
`timescale 1ns/1ps
`include "rmis_defs.vh"

module rmis_core (
	input wire mclk_in,
	input wire rst_n_in,
	input wire [5:0] home_pin_in,
	input wire [5:0] index_pin_in,
	input wire [2:0] din_pin_in,
	input wire [5:0] pos_hw_limit_pin_in,
	input wire [5:0] neg_hw_limit_pin_in,
	input wire cmd_valid_in,
	input wire [1:0] cmd_code_in,
	input wire axis_present_in,
	input wire [3:0] axis_num_in,
	input wire dist_present_in,
	input wire signed [63:0] dist_in,
	input wire [2:0] axes_fitted_in,
	input wire [5:0] axis_grouped_in,
	input wire [11:0] axis_traj_mode_in,
	input wire [383:0] axis_pos_in,
	input wire [383:0] sw_pos_limit_in,
	input wire [383:0] sw_neg_limit_in,
	input wire [383:0] max_disp_in,
	input wire tx_ready_in,
	output reg [31:0] status_two_out,
	output reg err_valid_out,
	output reg [3:0] err_axis_out,
	output reg [7:0] err_code_out,
	output reg [5:0] move_start_out,
	output reg [63:0] move_target_out,
	output reg tx_valid_out,
	output reg [7:0] tx_char_out,
	output reg busy_out
);

	reg [14:0] pin_sync1_r;
	reg [14:0] pin_sync2_r;
	reg [11:0] lim_sync1_r;
	reg [11:0] lim_sync2_r;
	reg [31:0] shift_r;
	reg [31:0] shift_nxt;
	reg [3:0] digits_r;
	reg [3:0] digits_nxt;
	reg tx_valid_nxt;
	reg [7:0] tx_char_nxt;
	reg err_valid_nxt;
	reg [3:0] err_axis_nxt;
	reg [7:0] err_code_nxt;
	reg [5:0] move_start_nxt;
	reg [63:0] move_target_nxt;
	reg signed [63:0] cur_pos;
	reg signed [63:0] target;
	reg signed [63:0] pos_lim;
	reg signed [63:0] neg_lim;
	reg signed [63:0] max_disp;
	reg signed [63:0] mag;
	reg [1:0] mode;
	reg [2:0] ax;
	reg [31:0] status_word;
	reg [7:0] hw_err;
	reg [7:0] sw_err;

	// Per-axis fields are unpacked once so the checks read plain arrays.
	wire signed [63:0] pos_arr [0:5];
	wire signed [63:0] pos_lim_arr [0:5];
	wire signed [63:0] neg_lim_arr [0:5];
	wire signed [63:0] max_disp_arr [0:5];
	wire [1:0] mode_arr [0:5];
	genvar g;
	generate
		for (g = 0; g < `RMIS_NUM_AXES; g = g + 1) begin : g_axis
			assign pos_arr[g] = axis_pos_in[g*64 +: 64];
			assign pos_lim_arr[g] = sw_pos_limit_in[g*64 +: 64];
			assign neg_lim_arr[g] = sw_neg_limit_in[g*64 +: 64];
			assign max_disp_arr[g] = max_disp_in[g*64 +: 64];
			assign mode_arr[g] = axis_traj_mode_in[g*2 +: 2];
		end
	endgenerate

	// Converts one nibble to its ASCII hexadecimal character.
	function [7:0] hex_char;
		input [3:0] nib;
		begin
			if (nib < 4'ha) begin
				hex_char = 8'h30 + {4'h0, nib};
			end else begin
				hex_char = 8'h37 + {4'h0, nib};
			end
		end
	endfunction

	// True for the two profile modes that a relative move may use.
	function mode_ok;
		input [1:0] m;
		begin
			if (m == `RMIS_TRAJ_TRAP || m == `RMIS_TRAJ_SCURVE) begin
				mode_ok = 1'b1;
			end else begin
				mode_ok = 1'b0;
			end
		end
	endfunction

	// limit by direction
	// Hardware limits only block travel toward the active switch; a zero move never blocks.
	function [7:0] hw_code;
		input signed [63:0] d;
		input pos_hit;
		input neg_hit;
		begin
			if (!d[63] && d != 64'h0 && pos_hit) begin
				hw_code = `RMIS_ERR_POS_HW_LIMIT;
			end else if (d[63] && neg_hit) begin
				hw_code = `RMIS_ERR_NEG_HW_LIMIT;
			end else begin
				hw_code = `RMIS_ERR_NONE;
			end
		end
	endfunction

	// magnitude bound first
	// An oversized step has no code of its own, so it is reported as a software limit.
	// The sign of the step picks the positive or the negative code.
	function [7:0] sw_code;
		input signed [63:0] d;
		input signed [63:0] m;
		input signed [63:0] bound;
		input signed [63:0] tgt;
		input signed [63:0] hi;
		input signed [63:0] lo;
		begin
			if (m > bound) begin
				sw_code = d[63] ? `RMIS_ERR_NEG_SW_LIMIT : `RMIS_ERR_POS_SW_LIMIT;
			end else if (tgt > hi) begin
				sw_code = `RMIS_ERR_POS_SW_LIMIT;
			end else if (tgt < lo) begin
				sw_code = `RMIS_ERR_NEG_SW_LIMIT;
			end else begin
				sw_code = `RMIS_ERR_NONE;
			end
		end
	endfunction

	// Synchronise home, index and digital input pins; the first stage feeds only the second.
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pin_sync1_r <= 15'h0000;
			pin_sync2_r <= 15'h0000;
		end else begin
			pin_sync1_r <= {din_pin_in, index_pin_in, home_pin_in};
			pin_sync2_r <= pin_sync1_r;
		end
	end

	// Limit switches are synchronised apart from the status pins as they gate motion.
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			lim_sync1_r <= 12'h000;
			lim_sync2_r <= 12'h000;
		end else begin
			lim_sync1_r <= {neg_hw_limit_pin_in, pos_hw_limit_pin_in};
			lim_sync2_r <= lim_sync1_r;
		end
	end

	always @* begin
		status_word = `RMIS_STATUS_RESET;
		status_word[`RMIS_HOME_LSB +: 6] = pin_sync2_r[5:0];
		status_word[`RMIS_INDEX_LSB +: 6] = pin_sync2_r[11:6];
		status_word[`RMIS_DIN_LSB +: 3] = pin_sync2_r[14:12];
	end

	always @* begin
		ax = axis_num_in[2:0] - 3'h1;
		cur_pos = pos_arr[ax];
		pos_lim = pos_lim_arr[ax];
		neg_lim = neg_lim_arr[ax];
		max_disp = max_disp_arr[ax];
		mode = mode_arr[ax];
		// The most negative distance stays negative here, so the magnitude bound check below does not catch it.
		mag = dist_in[63] ? -dist_in : dist_in;
		// target is current position plus displacement
		target = cur_pos + dist_in;
		hw_err = hw_code(dist_in, lim_sync2_r[ax], lim_sync2_r[6 + ax]);
		sw_err = sw_code(dist_in, mag, max_disp, target, pos_lim, neg_lim);

		shift_nxt = shift_r;
		digits_nxt = digits_r;
		tx_valid_nxt = 1'b0;
		tx_char_nxt = tx_char_out;
		err_valid_nxt = 1'b0;
		err_axis_nxt = err_axis_out;
		err_code_nxt = err_code_out;
		move_start_nxt = 6'h00;
		move_target_nxt = move_target_out;

		if (digits_r != 4'h0) begin
			// hex text out, most significant nibble first
			if (!tx_valid_out || tx_ready_in) begin
				tx_valid_nxt = 1'b1;
				tx_char_nxt = hex_char(shift_r[31:28]);
				shift_nxt = {shift_r[27:0], 4'h0};
				digits_nxt = digits_r - 4'h1;
			end else begin
				tx_valid_nxt = 1'b1;
			end
		// Commands wait until the last character has left, so acceptance matches busy.
		end else if (tx_valid_out) begin
			tx_valid_nxt = !tx_ready_in;
		end else if (cmd_valid_in && cmd_code_in == `RMIS_CMD_STATUS) begin
			shift_nxt = status_word;
			digits_nxt = `RMIS_HEX_DIGITS;
		end else if (cmd_valid_in && cmd_code_in == `RMIS_CMD_MOVE) begin
			err_valid_nxt = 1'b1;
			err_axis_nxt = axis_num_in;
			if (!axis_present_in) begin
				err_axis_nxt = 4'h0;
				err_code_nxt = `RMIS_ERR_AXIS_MISSING;
			end else if (axis_num_in == 4'h0 || axis_num_in > {1'b0, axes_fitted_in}) begin
				err_axis_nxt = 4'h0;
				err_code_nxt = `RMIS_ERR_AXIS_RANGE;
			end else if (!dist_present_in) begin
				err_axis_nxt = 4'h0;
				err_code_nxt = `RMIS_ERR_PARAM_MISSING;
			end else if (axis_grouped_in[ax]) begin
				err_code_nxt = `RMIS_ERR_GROUP;
			end else if (!mode_ok(mode)) begin
				err_code_nxt = `RMIS_ERR_TRAJ_MODE;
			// hardware limits in direction of travel
			end else if (hw_err != `RMIS_ERR_NONE) begin
				err_code_nxt = hw_err;
			// magnitude bound, checked ahead of the position limits
			end else if (sw_err != `RMIS_ERR_NONE) begin
				err_code_nxt = sw_err;
			end else begin
				err_valid_nxt = 1'b0;
				move_start_nxt[ax] = 1'b1;
				move_target_nxt = target;
			end
		end
	end

	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			status_two_out <= `RMIS_STATUS_RESET;
			shift_r <= 32'h00000000;
			digits_r <= 4'h0;
			tx_valid_out <= 1'b0;
			tx_char_out <= 8'h00;
			err_valid_out <= 1'b0;
			err_axis_out <= 4'h0;
			err_code_out <= `RMIS_ERR_NONE;
			move_start_out <= 6'h00;
			move_target_out <= 64'h0;
			busy_out <= 1'b0;
		end else begin
			status_two_out <= status_word;
			shift_r <= shift_nxt;
			digits_r <= digits_nxt;
			tx_valid_out <= tx_valid_nxt;
			tx_char_out <= tx_char_nxt;
			err_valid_out <= err_valid_nxt;
			err_axis_out <= err_axis_nxt;
			err_code_out <= err_code_nxt;
			move_start_out <= move_start_nxt;
			move_target_out <= move_target_nxt;
			// Busy follows the next state so it drops in the cycle the last character is taken.
			busy_out <= (digits_nxt != 4'h0) || tx_valid_nxt;
		end
	end

endmodule // rmis_core

// [tb/rmis_monitor.sv]
/* Port assertions for rmis_core.
   Assumes binding to rmis_core and rmis_defs.vh on the include path. */
`timescale 1ns/1ps
`include "rmis_defs.vh"
module rmis_monitor (
	input wire mclk_in, rst_n_in, cmd_valid_in, axis_present_in, dist_present_in,
	input wire tx_ready_in, busy_out, err_valid_out, tx_valid_out,
	input wire [5:0] home_pin_in, axis_grouped_in, move_start_out,
	input wire [2:0] din_pin_in, axes_fitted_in,
	input wire [1:0] cmd_code_in,
	input wire [3:0] axis_num_in, err_axis_out,
	input wire signed [63:0] dist_in,
	input wire [383:0] axis_pos_in,
	input wire [31:0] status_two_out,
	input wire [7:0] err_code_out, tx_char_out,
	input wire [63:0] move_target_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	wire mv = cmd_valid_in && cmd_code_in == `RMIS_CMD_MOVE && !busy_out;
	AST_HOME: assert property ($stable(home_pin_in)[*4] |-> status_two_out[5:0] == home_pin_in)
		else $error("home bits wrong");
	AST_RSVD: assert property (status_two_out[7:6] == 2'h0 && status_two_out[15:14] == 2'h0
		&& status_two_out[31:19] == 13'h0) else $error("reserved bits set");
	AST_DIN: assert property ($stable(din_pin_in)[*4] |-> status_two_out[18:16] == din_pin_in)
		else $error("input bits wrong");
	AST_TXHOLD: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_char_out))
		else $error("char dropped");
	AST_STAT: assert property (cmd_valid_in && cmd_code_in == `RMIS_CMD_STATUS && !busy_out |=> busy_out ##1 tx_valid_out)
		else $error("no status text");
	AST_NOAXIS: assert property (mv && !axis_present_in |=> err_valid_out && err_code_out == 8'h25
		&& err_axis_out == 4'h0) else $error("missing axis code wrong");
	AST_NODIST: assert property (mv && axis_present_in && axis_num_in == 4'h1 && axes_fitted_in != 3'h0
		&& !dist_present_in |=> err_valid_out && err_code_out == 8'h26 && move_start_out == 6'h0) else $error("missing distance");
	AST_GROUP: assert property (mv && axis_present_in && axis_num_in == 4'h6 && axes_fitted_in == 3'h6 && dist_present_in
		&& axis_grouped_in[5] |=> err_valid_out && err_code_out == 8'h1f && err_axis_out == 4'h6) else $error("group code wrong");
	AST_REPLY: assert property (mv |=> err_valid_out != (move_start_out != 6'h0)) else $error("move reply wrong");
	AST_CAUSE: assert property (err_valid_out || move_start_out != 6'h0 |-> $past(mv)) else $error("spurious move");
	AST_TARGET: assert property (mv |=> move_start_out == 6'h0
		|| move_target_out == $past(axis_pos_in[{axis_num_in - 4'h1, 6'h0} +: 64]) + $past(dist_in)) else $error("bad target");
endmodule // rmis_monitor
bind rmis_core rmis_monitor mon (.*);

// [tb/rmis_host.sv]
/* Host text sink: takes status characters, stalling every other cycle.
   Assumes uppercase ASCII hex, most significant digit first. */
`timescale 1ns/1ps
module rmis_host (
	input wire clk_in,
	input wire rst_n_in,
	input wire tx_valid_in,
	input wire [7:0] tx_char_in,
	output reg tx_ready_out,
	output reg [31:0] word_out,
	output reg [3:0] count_out
);
	// A character outside 0-9 and A-F turns the word unknown so it never matches.
	function [3:0] nib(input [7:0] c);
		nib = (c >= 8'h30 && c <= 8'h39) ? c[3:0] : (c >= 8'h41 && c <= 8'h46) ? c[3:0] + 4'h9 : 4'hx;
	endfunction
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tx_ready_out <= 1'b0;
			word_out <= 32'h0;
			count_out <= 4'h0;
		end else begin
			tx_ready_out <= !tx_ready_out;
			if (tx_valid_in && tx_ready_out) begin
				count_out <= count_out + 4'h1;
				word_out <= {word_out[27:0], nib(tx_char_in)};
			end
		end
	end
endmodule // rmis_host

// [tb/tb_top.sv]
/* Self-checking bench for rmis_core with a stalling host sink.
   Assumes rmis_defs.vh on the include path. */
`timescale 1ns/1ps
`include "rmis_defs.vh"
module tb_top;
	reg mclk_in = 0, rst_n_in = 0, cmd_valid_in = 0, axis_present_in = 0, dist_present_in = 0;
	reg [5:0] home_pin_in = 6'h2a, index_pin_in = 6'h15, pos_hw_limit_pin_in = 6'h04, neg_hw_limit_pin_in = 6'h08;
	reg [5:0] axis_grouped_in = 6'h20;
	reg [2:0] din_pin_in = 3'h5, axes_fitted_in = 3'h6;
	reg [1:0] cmd_code_in = 2'h0;
	reg [3:0] axis_num_in = 4'h0;
	reg signed [63:0] dist_in = 64'sh0;
	reg [11:0] axis_traj_mode_in = 12'h204;
	reg [383:0] axis_pos_in, sw_pos_limit_in, sw_neg_limit_in, max_disp_in;
	wire err_valid_out, tx_valid_out, busy_out, tx_ready_in;
	wire [31:0] status_two_out, host_word;
	wire [3:0] err_axis_out, host_cnt;
	wire [7:0] err_code_out, tx_char_out;
	wire [5:0] move_start_out;
	wire [63:0] move_target_out;
	integer err_total = 0, cmp_count = 0, cyc = 0, i;
	rmis_core dut (.*);
	rmis_host host (.clk_in(mclk_in), .rst_n_in(rst_n_in), .tx_valid_in(tx_valid_out), .tx_char_in(tx_char_out),
		.tx_ready_out(tx_ready_in), .word_out(host_word), .count_out(host_cnt));
	always #2 mclk_in = !mclk_in;
	always @(posedge mclk_in) begin
		cyc = cyc + 1;
		if (cyc == 2000) begin
			err_total = err_total + 1;
			give_verdict;
		end
	end
	task chk(input [63:0] s, input [63:0] e);
		begin
			cmp_count = cmp_count + 1;
			if (s !== e) begin
				err_total = err_total + 1;
				$display("unexpected at %0t: saw %h want %h", $time, s, e);
			end
		end
	endtask
	task give_verdict;
		begin
			if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
			else $display("DONE - FAIL");
			$finish;
		end
	endtask
	task mv(input ap, input [3:0] ax, input dp, input signed [63:0] d, input [7:0] ec, input [3:0] ea);
		begin
			cmd_valid_in = 1;
			cmd_code_in = `RMIS_CMD_MOVE;
			axis_present_in = ap;
			axis_num_in = ax;
			dist_present_in = dp;
			dist_in = d;
			@(posedge mclk_in) #1 cmd_valid_in = 0;
			chk(err_valid_out, ec != 8'h0);
			chk(move_start_out, ec != 8'h0 ? 6'h0 : 6'h1 << (ax - 4'h1));
			if (ec != 8'h0) begin
				chk(err_code_out, ec);
				chk(err_axis_out, ea);
			end else chk(move_target_out, $signed(axis_pos_in[(ax - 32'd1) * 64 +: 64]) + d);
			@(posedge mclk_in) #1;
		end
	endtask
	initial begin
		for (i = 0; i < 6; i = i + 1) begin
			axis_pos_in[i * 64 +: 64] = (i + 1) * 1000;
			sw_pos_limit_in[i * 64 +: 64] = 64'sd1000000;
			sw_neg_limit_in[i * 64 +: 64] = -64'sd1000000;
			max_disp_in[i * 64 +: 64] = 64'sd2000000;
		end
		repeat (8) @(posedge mclk_in);
		#1 rst_n_in = 1;
		repeat (4) @(posedge mclk_in);
		#1 chk(status_two_out, 32'h0005152a);
		cmd_valid_in = 1;
		cmd_code_in = `RMIS_CMD_STATUS;
		@(posedge mclk_in) #1 cmd_code_in = `RMIS_CMD_MOVE;
		@(posedge mclk_in) #1 cmd_valid_in = 0;
		chk(err_valid_out, 1'b0);
		for (i = 0; i < 100 && host_cnt !== 4'h8; i = i + 1) @(posedge mclk_in);
		#1 chk(host_word, 32'h0005152a);
		mv(0, 4'h1, 1, 10, 8'h25, 4'h0);
		mv(1, 4'h0, 1, 10, 8'h09, 4'h0);
		mv(1, 4'h7, 1, 10, 8'h09, 4'h0);
		mv(1, 4'h1, 0, 0, 8'h26, 4'h0);
		mv(1, 4'h6, 1, 10, 8'h1f, 4'h6);
		mv(1, 4'h5, 1, 10, 8'h20, 4'h5);
		mv(1, 4'h3, 1, 10, 8'h04, 4'h3);
		mv(1, 4'h4, 1, -10, 8'h05, 4'h4);
		mv(1, 4'h1, 1, 1500000, 8'h06, 4'h1);
		mv(1, 4'h1, 1, -1500000, 8'h07, 4'h1);
		mv(1, 4'h1, 1, 3000000, 8'h06, 4'h1);
		mv(1, 4'h2, 1, -50, 8'h0, 4'h0);
		mv(1, 4'h2, 1, -20, 8'h0, 4'h0);
		mv(1, 4'h1, 1, 7, 8'h0, 4'h0);
		give_verdict;
	end
endmodule // tb_top
